// File: logic/exec_cfg.svh
// Purpose: constants for the return, rotate, subtract and sleep execution block
// Assumes: 8-bit data path, 7-bit file register address, 15-bit program counter
// Notes: reset values and field positions live here; the package holds the types
`ifndef EXEC_CFG_SVH
`define EXEC_CFG_SVH

`define DATA_W 8
`define DATA_MSB 7
`define NIB_MSB 3
`define FADDR_W 7
`define PC_W 15
`define DEST_ACCUM 1'b0
`define DEST_FILE 1'b1
`define ACCUM_RST 8'h00
`define FLAG_RST 1'b0
`define PD_RST 1'b1
`define TO_RST 1'b1

`endif

// File: logic/exec_pkg.sv
// Purpose: types shared by the execution block
// Assumes: decode has already mapped instruction words onto op_t
// Notes: no codes given; members take values from 0 upward in listed order
package exec_pkg;
	// instructions this block executes
	typedef enum logic [2:0] {
		op_return_with_literal,
		op_rotate_left_through_carry,
		op_rotate_right_through_carry,
		op_subtract_from_literal,
		op_subtract_register,
		op_sleep
	} op_t;

	// sequencing of multi-cycle and terminal instructions
	typedef enum logic [1:0] {
		st_run,
		st_return_second,
		st_asleep
	} state_t;
endpackage : exec_pkg

// File: logic/alu_if.sv
// Purpose: operand and result bundle between the core and its arithmetic units
// Assumes: purely combinational units on the far side
// Notes: the core drives operands, the units drive results
`timescale 1ns/1ps
`include "exec_cfg.svh"
interface alu_if;
	logic [`DATA_W-1:0] operand_a;
	logic [`DATA_W-1:0] operand_b;
	logic carry_in;
	logic rotate_left;
	logic [`DATA_W-1:0] rot_result;
	logic rot_carry;
	logic [`DATA_W-1:0] sub_result;
	logic sub_carry;
	logic sub_digit_carry;
	logic sub_zero;

	modport core (output operand_a, operand_b, carry_in, rotate_left,
		input rot_result, rot_carry, sub_result, sub_carry, sub_digit_carry, sub_zero);
	modport rot (input operand_a, carry_in, rotate_left, output rot_result, rot_carry);
	modport sub (input operand_a, operand_b, output sub_result, sub_carry, sub_digit_carry, sub_zero);
endinterface : alu_if

// File: logic/rotate_unit.sv
// Purpose: one-bit rotate through carry, either direction
// Assumes: operand_a is the file register value
// Notes: combinational
`timescale 1ns/1ps
`include "exec_cfg.svh"
module rotate_unit (
	alu_if.rot alu
);
	// carry enters the vacated end, the bit shifted out becomes carry
	always_comb begin
		if (alu.rotate_left) begin
			alu.rot_result = {alu.operand_a[`DATA_MSB-1:0], alu.carry_in};
			alu.rot_carry = alu.operand_a[`DATA_MSB];
		end else begin
			alu.rot_result = {alu.carry_in, alu.operand_a[`DATA_MSB:1]};
			alu.rot_carry = alu.operand_a[0];
		end
	end
endmodule : rotate_unit

// File: logic/subtract_unit.sv
// Purpose: operand_a minus operand_b with borrow-style flags
// Assumes: operand_b is always the accumulator
// Notes: carry is the inverse of borrow, so equal operands give carry 1
`timescale 1ns/1ps
`include "exec_cfg.svh"
module subtract_unit (
	alu_if.sub alu
);
	logic [`DATA_W:0] wide_diff;

	// extra bit of the difference is the borrow out
	always_comb begin
		wide_diff = {1'b0, alu.operand_a} - {1'b0, alu.operand_b};
		alu.sub_result = wide_diff[`DATA_W-1:0];
		alu.sub_carry = ~wide_diff[`DATA_W];
		alu.sub_digit_carry = (alu.operand_b[`NIB_MSB:0] <= alu.operand_a[`NIB_MSB:0]);
		alu.sub_zero = (wide_diff[`DATA_W-1:0] == '0);
	end
endmodule : subtract_unit

// File: logic/exec_core.sv
// Purpose: executes return-with-literal, rotates, subtracts and sleep
// Assumes: file_operand is the addressed register's value, valid with instr_valid
// Notes: the return stack, fetch, decode and the watchdog itself sit outside
`timescale 1ns/1ps
`include "exec_cfg.svh"
module exec_core (
	input wire logic clk,
	input wire logic rst,
	input wire logic instr_valid,
	input wire exec_pkg::op_t opcode,
	input wire logic [`DATA_W-1:0] literal,
	input wire logic [`FADDR_W-1:0] file_addr,
	input wire logic dest_sel,
	input wire logic [`DATA_W-1:0] file_operand,
	input wire logic [`PC_W-1:0] top_of_return_stack,
	output logic instr_ready_ff,
	output logic [`DATA_W-1:0] accum_ff,
	output logic carry_flag_ff,
	output logic digit_carry_flag_ff,
	output logic zero_flag_ff,
	output logic power_down_flag_ff,
	output logic time_out_flag_ff,
	output logic file_we_ff,
	output logic [`FADDR_W-1:0] file_waddr_ff,
	output logic [`DATA_W-1:0] file_wdata_ff,
	output logic pc_load_ff,
	output logic [`PC_W-1:0] pc_value_ff,
	output logic watchdog_clear_ff,
	output logic prescaler_clear_ff,
	output logic osc_stop_ff
);
	import exec_pkg::*;

	state_t state_ff;
	state_t nxt_state;
	logic nxt_instr_ready;
	logic [`DATA_W-1:0] nxt_accum;
	logic nxt_carry;
	logic nxt_digit_carry;
	logic nxt_zero;
	logic nxt_power_down;
	logic nxt_time_out;
	logic nxt_file_we;
	logic [`FADDR_W-1:0] nxt_file_waddr;
	logic [`DATA_W-1:0] nxt_file_wdata;
	logic nxt_pc_load;
	logic [`PC_W-1:0] nxt_pc_value;
	logic nxt_watchdog_clear;
	logic nxt_prescaler_clear;
	logic nxt_osc_stop;
	logic take;
	logic [`DATA_W-1:0] result;
	logic [`DATA_W-1:0] minuend;

	alu_if alu ();

	// instruction accepted only while running and idle
	assign take = instr_valid & instr_ready_ff;

	// literal subtract uses k, register subtract uses the file value
	assign minuend = (opcode == op_subtract_from_literal) ? literal : file_operand;
	assign alu.operand_a = (opcode == op_subtract_from_literal || opcode == op_subtract_register) ? minuend : file_operand;
	assign alu.operand_b = accum_ff;
	assign alu.carry_in = carry_flag_ff;
	assign alu.rotate_left = (opcode == op_rotate_left_through_carry);

	rotate_unit u_rot (
		.alu(alu.rot)
	);

	subtract_unit u_sub (
		.alu(alu.sub)
	);

	// next values for sequencing, accumulator, flags and side outputs
	always_comb begin
		nxt_state = state_ff;
		nxt_accum = accum_ff;
		nxt_carry = carry_flag_ff;
		nxt_digit_carry = digit_carry_flag_ff;
		nxt_zero = zero_flag_ff;
		nxt_power_down = power_down_flag_ff;
		nxt_time_out = time_out_flag_ff;
		nxt_file_we = 1'b0;
		nxt_file_waddr = file_waddr_ff;
		nxt_file_wdata = file_wdata_ff;
		nxt_pc_load = 1'b0;
		nxt_pc_value = pc_value_ff;
		nxt_watchdog_clear = 1'b0;
		nxt_prescaler_clear = 1'b0;
		nxt_osc_stop = osc_stop_ff;
		result = alu.sub_result;
		unique case (state_ff)
			st_run: begin
				if (take) begin
					unique case (opcode)
						op_return_with_literal: begin
							nxt_accum = literal;
							nxt_pc_load = 1'b1;
							nxt_pc_value = top_of_return_stack;
							nxt_state = st_return_second;
						end
						op_rotate_left_through_carry, op_rotate_right_through_carry: begin
							result = alu.rot_result;
							nxt_carry = alu.rot_carry;
						end
						op_subtract_from_literal, op_subtract_register: begin
							result = alu.sub_result;
							nxt_carry = alu.sub_carry;
							nxt_digit_carry = alu.sub_digit_carry;
							nxt_zero = alu.sub_zero;
						end
						op_sleep: begin
							nxt_power_down = 1'b0;
							nxt_time_out = 1'b1;
							nxt_watchdog_clear = 1'b1;
							nxt_prescaler_clear = 1'b1;
							nxt_osc_stop = 1'b1;
							nxt_state = st_asleep;
						end
					endcase
					// literal subtract always lands in the accumulator
					if (opcode == op_subtract_from_literal) begin
						nxt_accum = result;
					end else if (opcode != op_return_with_literal && opcode != op_sleep) begin
						if (dest_sel == `DEST_FILE) begin
							nxt_file_we = 1'b1;
							nxt_file_waddr = file_addr;
							nxt_file_wdata = result;
						end else begin
							nxt_accum = result;
						end
					end
				end
			end
			// second cycle of the return: pipeline refill, nothing taken
			st_return_second: begin
				nxt_state = st_run;
			end
			// only reset leaves sleep; no wake source is modelled here
			st_asleep: begin
				nxt_state = st_asleep;
			end
		endcase
		nxt_instr_ready = (nxt_state == st_run);
	end

	// register stage only
	always_ff @(posedge clk) begin
		if (rst) begin
			state_ff <= st_run;
			instr_ready_ff <= 1'b0;
			accum_ff <= `ACCUM_RST;
			carry_flag_ff <= `FLAG_RST;
			digit_carry_flag_ff <= `FLAG_RST;
			zero_flag_ff <= `FLAG_RST;
			power_down_flag_ff <= `PD_RST;
			time_out_flag_ff <= `TO_RST;
			file_we_ff <= 1'b0;
			file_waddr_ff <= '0;
			file_wdata_ff <= '0;
			pc_load_ff <= 1'b0;
			pc_value_ff <= '0;
			watchdog_clear_ff <= 1'b0;
			prescaler_clear_ff <= 1'b0;
			osc_stop_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			instr_ready_ff <= nxt_instr_ready;
			accum_ff <= nxt_accum;
			carry_flag_ff <= nxt_carry;
			digit_carry_flag_ff <= nxt_digit_carry;
			zero_flag_ff <= nxt_zero;
			power_down_flag_ff <= nxt_power_down;
			time_out_flag_ff <= nxt_time_out;
			file_we_ff <= nxt_file_we;
			file_waddr_ff <= nxt_file_waddr;
			file_wdata_ff <= nxt_file_wdata;
			pc_load_ff <= nxt_pc_load;
			pc_value_ff <= nxt_pc_value;
			watchdog_clear_ff <= nxt_watchdog_clear;
			prescaler_clear_ff <= nxt_prescaler_clear;
			osc_stop_ff <= nxt_osc_stop;
		end
	end

	// checks on the executed semantics
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_ret_accum;
		take && opcode == op_return_with_literal |=> accum_ff == $past(literal);
	endproperty
	a_ret_accum: assert property (p_ret_accum) else $error("return did not load literal");

	property p_ret_pc;
		take && opcode == op_return_with_literal |=>
			pc_load_ff && pc_value_ff == $past(top_of_return_stack) && !instr_ready_ff
			##1 !pc_load_ff && instr_ready_ff;
	endproperty
	a_ret_pc: assert property (p_ret_pc) else $error("return pc load or two-cycle timing wrong");

	property p_ret_flags;
		take && opcode == op_return_with_literal |=> carry_flag_ff == $past(carry_flag_ff)
			&& digit_carry_flag_ff == $past(digit_carry_flag_ff) && zero_flag_ff == $past(zero_flag_ff);
	endproperty
	a_ret_flags: assert property (p_ret_flags) else $error("return changed a flag");

	property p_rotl;
		take && opcode == op_rotate_left_through_carry && dest_sel == `DEST_ACCUM |=>
			accum_ff == {$past(file_operand[`DATA_MSB-1:0]), $past(carry_flag_ff)}
			&& carry_flag_ff == $past(file_operand[`DATA_MSB]) && zero_flag_ff == $past(zero_flag_ff)
			&& instr_ready_ff;
	endproperty
	a_rotl: assert property (p_rotl) else $error("rotate left result or carry wrong");

	property p_rotr;
		take && opcode == op_rotate_right_through_carry && dest_sel == `DEST_FILE |=>
			file_wdata_ff == {$past(carry_flag_ff), $past(file_operand[`DATA_MSB:1])}
			&& carry_flag_ff == $past(file_operand[0]) && digit_carry_flag_ff == $past(digit_carry_flag_ff);
	endproperty
	a_rotr: assert property (p_rotr) else $error("rotate right result or carry wrong");

	property p_dest_file;
		take && dest_sel == `DEST_FILE && (opcode == op_rotate_left_through_carry
			|| opcode == op_rotate_right_through_carry || opcode == op_subtract_register) |=>
			file_we_ff && file_waddr_ff == $past(file_addr) && accum_ff == $past(accum_ff);
	endproperty
	a_dest_file: assert property (p_dest_file) else $error("destination 1 did not write the register");

	property p_subtract_from_literal;
		take && opcode == op_subtract_from_literal |=>
			accum_ff == 8'($past(literal) - $past(accum_ff)) && !file_we_ff
			&& carry_flag_ff == ($past(accum_ff) <= $past(literal));
	endproperty
	a_subtract_from_literal: assert property (p_subtract_from_literal) else $error("literal subtract result or carry wrong");

	property p_subtract_register;
		take && opcode == op_subtract_register && dest_sel == `DEST_ACCUM |=>
			accum_ff == 8'($past(file_operand) - $past(accum_ff))
			&& carry_flag_ff == ($past(accum_ff) <= $past(file_operand))
			&& digit_carry_flag_ff == ($past(accum_ff[`NIB_MSB:0]) <= $past(file_operand[`NIB_MSB:0]));
	endproperty
	a_subtract_register: assert property (p_subtract_register) else $error("register subtract result or flags wrong");

	property p_zero;
		take && opcode == op_subtract_from_literal |=> zero_flag_ff == ($past(literal) == $past(accum_ff));
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong after subtract");

	property p_sleep_flags;
		take && opcode == op_sleep |=> !power_down_flag_ff && time_out_flag_ff
			&& watchdog_clear_ff && prescaler_clear_ff ##1 !watchdog_clear_ff && !prescaler_clear_ff;
	endproperty
	a_sleep_flags: assert property (p_sleep_flags) else $error("sleep flags or watchdog clear wrong");

	property p_asleep;
		osc_stop_ff |=> osc_stop_ff && !instr_ready_ff && !file_we_ff && accum_ff == $past(accum_ff);
	endproperty
	a_asleep: assert property (p_asleep) else $error("core ran while asleep");

	property p_rotl_file;
		take && opcode == op_rotate_left_through_carry && dest_sel == `DEST_FILE |=>
			file_we_ff && file_wdata_ff == {$past(file_operand[`DATA_MSB-1:0]), $past(carry_flag_ff)}
			&& carry_flag_ff == $past(file_operand[`DATA_MSB]) && accum_ff == $past(accum_ff)
			&& digit_carry_flag_ff == $past(digit_carry_flag_ff);
	endproperty
	a_rotl_file: assert property (p_rotl_file) else $error("rotate left to register wrong");

	property p_rotr_accum;
		take && opcode == op_rotate_right_through_carry && dest_sel == `DEST_ACCUM |=>
			accum_ff == {$past(carry_flag_ff), $past(file_operand[`DATA_MSB:1])} && !file_we_ff
			&& carry_flag_ff == $past(file_operand[0]) && zero_flag_ff == $past(zero_flag_ff);
	endproperty
	a_rotr_accum: assert property (p_rotr_accum) else $error("rotate right to accumulator wrong");

	property p_subtract_register_file;
		take && opcode == op_subtract_register && dest_sel == `DEST_FILE |=>
			file_we_ff && file_wdata_ff == 8'($past(file_operand) - $past(accum_ff)) && accum_ff == $past(accum_ff)
			&& carry_flag_ff == ($past(accum_ff) <= $past(file_operand));
	endproperty
	a_subtract_register_file: assert property (p_subtract_register_file) else $error("register subtract to register wrong");

	property p_subtract_from_literal_digit;
		take && opcode == op_subtract_from_literal |=>
			digit_carry_flag_ff == ($past(accum_ff[`NIB_MSB:0]) <= $past(literal[`NIB_MSB:0]));
	endproperty
	a_subtract_from_literal_digit: assert property (p_subtract_from_literal_digit) else $error("literal subtract digit carry wrong");

	property p_zero_reg;
		take && opcode == op_subtract_register |=> zero_flag_ff == ($past(file_operand) == $past(accum_ff));
	endproperty
	a_zero_reg: assert property (p_zero_reg) else $error("zero flag wrong after register subtract");

	// a refused slot must leave no trace, else a return would run a third cycle
	property p_refused;
		instr_valid && !instr_ready_ff |=> !file_we_ff && !pc_load_ff && accum_ff == $past(accum_ff)
			&& carry_flag_ff == $past(carry_flag_ff);
	endproperty
	a_refused: assert property (p_refused) else $error("refused instruction changed state");

	property p_sleep_hold;
		take && opcode == op_sleep |=> accum_ff == $past(accum_ff) && !file_we_ff && !pc_load_ff
			&& osc_stop_ff && !instr_ready_ff;
	endproperty
	a_sleep_hold: assert property (p_sleep_hold) else $error("sleep changed data or kept running");

	cover property (take && opcode == op_return_with_literal ##2 instr_ready_ff);
	cover property (take && opcode == op_subtract_from_literal && literal == accum_ff);
	cover property (take && opcode == op_rotate_right_through_carry && dest_sel == `DEST_FILE);
	cover property (take && opcode == op_sleep ##1 osc_stop_ff);
endmodule : exec_core

// File: test/cpu_return_rotate_subtract_sleep_bench.sv
// Purpose: self-checking bench for the return, rotate, subtract and sleep execution block
// Assumes: registered outputs are settled 1 ns after each rising edge
// Notes: a cycle model in the bench is compared with every output on every cycle
`timescale 1ns/1ps
`include "exec_cfg.svh"
module cpu_return_rotate_subtract_sleep_bench;
	import exec_pkg::*;
	logic clk, rst, instr_valid, dest_sel;
	op_t opcode;
	logic [`DATA_W-1:0] literal, file_operand, accum_ff, file_wdata_ff;
	logic [`FADDR_W-1:0] file_addr, file_waddr_ff;
	logic [`PC_W-1:0] top_of_return_stack, pc_value_ff;
	logic instr_ready_ff, carry_flag_ff, digit_carry_flag_ff, zero_flag_ff, power_down_flag_ff, time_out_flag_ff;
	logic file_we_ff, pc_load_ff, watchdog_clear_ff, prescaler_clear_ff, osc_stop_ff;
	int seed = 20;
	int errors = 0;
	int num_checks = 0;
	int acc, c, dcy, z, pwd, tof, rdy, we, wa, wd, pcl, pcv, wdc, psc, osc, res, opa;

	exec_core i_dut (.clk(clk), .rst(rst), .instr_valid(instr_valid), .opcode(opcode), .literal(literal),
		.file_addr(file_addr), .dest_sel(dest_sel), .file_operand(file_operand),
		.top_of_return_stack(top_of_return_stack), .instr_ready_ff(instr_ready_ff), .accum_ff(accum_ff),
		.carry_flag_ff(carry_flag_ff), .digit_carry_flag_ff(digit_carry_flag_ff), .zero_flag_ff(zero_flag_ff),
		.power_down_flag_ff(power_down_flag_ff), .time_out_flag_ff(time_out_flag_ff), .file_we_ff(file_we_ff),
		.file_waddr_ff(file_waddr_ff), .file_wdata_ff(file_wdata_ff), .pc_load_ff(pc_load_ff),
		.pc_value_ff(pc_value_ff), .watchdog_clear_ff(watchdog_clear_ff), .prescaler_clear_ff(prescaler_clear_ff),
		.osc_stop_ff(osc_stop_ff));

	// free-running 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// one compare; four-state so an unknown never matches
	task automatic chk(input string nm, input logic [15:0] got, input int exp);
		num_checks++;
		if (got !== exp[15:0]) begin
			errors++;
			$display("[FAIL] t=%0t %s got=%h exp=%h", $time, nm, got, exp[15:0]);
		end
	endtask : chk

	// cycle model: reads inputs as the design does at the edge, then compares once outputs settle
	always @(posedge clk) begin
		if (rst) begin
			rdy = 0; acc = 0; c = 0; dcy = 0; z = 0; pwd = 1; tof = 1; we = 0; wa = 0; wd = 0;
			pcl = 0; pcv = 0; wdc = 0; psc = 0; osc = 0;
		end else begin
			we = 0; pcl = 0; wdc = 0; psc = 0;
			if (rdy && instr_valid) begin
				opa = (opcode == op_subtract_from_literal) ? literal : file_operand;
				case (opcode)
					op_return_with_literal: begin
						acc = literal; pcl = 1; pcv = top_of_return_stack; rdy = 0;
					end
					op_rotate_left_through_carry: begin
						res = ((opa << 1) | c) & 255; c = opa >> 7;
					end
					op_rotate_right_through_carry: begin
						res = (c << 7) | (opa >> 1); c = opa & 1;
					end
					op_sleep: begin
						pwd = 0; tof = 1; wdc = 1; psc = 1; osc = 1; rdy = 0;
					end
					default: begin
						res = (opa - acc) & 255; c = acc <= opa; dcy = (acc & 15) <= (opa & 15); z = res == 0;
					end
				endcase
				if (opcode == op_subtract_from_literal)
					acc = res;
				else if (opcode inside {op_rotate_left_through_carry, op_rotate_right_through_carry, op_subtract_register}) begin
					if (dest_sel) begin
						we = 1; wa = file_addr; wd = res;
					end else
						acc = res;
				end
			end else if (!osc)
				rdy = 1;
		end
		#1;
		chk("ready", instr_ready_ff, rdy);
		chk("accum", accum_ff, acc);
		chk("carry", carry_flag_ff, c);
		chk("dcarry", digit_carry_flag_ff, dcy);
		chk("zero", zero_flag_ff, z);
		chk("pdown", power_down_flag_ff, pwd);
		chk("tout", time_out_flag_ff, tof);
		chk("we", file_we_ff, we);
		chk("waddr", file_waddr_ff, wa);
		chk("wdata", file_wdata_ff, wd);
		chk("pcload", pc_load_ff, pcl);
		chk("pcval", pc_value_ff, pcv);
		chk("wdclr", watchdog_clear_ff, wdc);
		chk("psclr", prescaler_clear_ff, psc);
		chk("oscstop", osc_stop_ff, osc);
	end

	// present one cycle of stimulus; address and return address are always random
	task automatic go(input op_t op, input int k, input int f, input logic d, input logic v);
		int r;
		r = $random(seed);
		instr_valid <= v;
		opcode <= op;
		literal <= k[7:0];
		file_operand <= f[7:0];
		dest_sel <= d;
		file_addr <= r[6:0];
		top_of_return_stack <= r[22:8];
		@(posedge clk);
	endtask : go

	// random non-sleep traffic with occasional idle cycles
	task automatic rnd(input int n);
		int r;
		for (int i = 0; i < n; i++) begin
			r = $random(seed);
			go(op_t'(3'((r & 32'h7fff) % 5)), $random(seed), $random(seed), r[20], r[17:16] != 2'h0);
		end
	endtask : rnd

	// verdict, reached from the main sequence or the watchdog
	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_sim

	// hang guard: the tests need well under 1000 cycles
	initial begin
		#200000;
		errors++;
		end_sim();
	end

	initial begin
		rst = 1'b1;
		instr_valid = 1'b0;
		opcode = op_return_with_literal;
		literal = 8'h00;
		file_operand = 8'h00;
		file_addr = 7'h00;
		dest_sel = 1'b0;
		top_of_return_stack = 15'h0000;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		go(op_sleep, 0, 0, 0, 0);
		go(op_sleep, 0, 0, 0, 0);
		// worked cases: rotate example, equal operands, borrow, refused slot after return
		go(op_rotate_left_through_carry, 0, 'he6, 0, 1);
		go(op_subtract_from_literal, 'hcc, 0, 1, 1);
		go(op_return_with_literal, 'hff, 0, 0, 1);
		go(op_subtract_from_literal, 0, 0, 0, 1);
		go(op_subtract_from_literal, 0, 0, 0, 1);
		go(op_subtract_register, 0, 'h10, 1, 1);
		go(op_rotate_right_through_carry, 0, 'h01, 1, 1);
		go(op_rotate_right_through_carry, 0, 'h00, 0, 1);
		$display("test directed done");
		rnd(400);
		$display("test random done");
		// idle slot: a return at the end of the random run must not swallow the sleep
		go(op_sleep, 0, 0, 0, 0);
		go(op_sleep, 0, 0, 0, 1);
		go(op_return_with_literal, 'h5a, 0, 0, 1);
		go(op_subtract_register, 0, 'h33, 1, 1);
		go(op_sleep, 0, 0, 0, 0);
		$display("test sleep done");
		rst <= 1'b1;
		rnd(3);
		rst <= 1'b0;
		go(op_sleep, 0, 0, 0, 0);
		rnd(100);
		go(op_sleep, 0, 0, 0, 0);
		$display("test reset rerun done");
		end_sim();
	end
endmodule : cpu_return_rotate_subtract_sleep_bench
